// [common/stp_pkg.sv]
// Constants shared by the test-pattern insertion block: register map,
// reset values, control bit positions and serial frame layout.
// Assumes 16-bit registers behind a 9-bit register address.
package stp_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 9;
   localparam int REG_W = 16;
   localparam int LANES = 4;
   localparam int PIX_W = 10;
   localparam int LOW_W = 8;
   localparam int HIGH_W = 2;
   localparam int CAL_CH = 8;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [8:0] ADDR_CAL_FLAGS = 9'h088;
   localparam logic [8:0] ADDR_RSV_STAT_A = 9'h089;
   localparam logic [8:0] ADDR_RSV_STAT_B = 9'h08a;
   localparam logic [8:0] ADDR_RSV_STAT_C = 9'h08b;
   localparam logic [8:0] ADDR_RSV_SET_A = 9'h08c;
   localparam logic [8:0] ADDR_RSV_SET_B = 9'h08d;
   localparam logic [8:0] ADDR_CTRL = 9'h090;
   localparam logic [8:0] ADDR_RSV_SET_C = 9'h091;
   localparam logic [8:0] ADDR_LOW01 = 9'h092;
   localparam logic [8:0] ADDR_LOW23 = 9'h093;
   localparam logic [8:0] ADDR_RSV_SET_D = 9'h094;
   localparam logic [8:0] ADDR_HIGH = 9'h096;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_LOW01 = 16'h0100;
   localparam logic [15:0] RST_LOW23 = 16'h0302;
   localparam logic [15:0] RST_HIGH = 16'h0000;
   localparam logic [15:0] RST_RSV_SET_B = 16'hffff;
   localparam logic [15:0] RST_RSV_SET_D = 16'h0504;

   // ************************************************************
   // Control bit positions
   // ************************************************************
   localparam int BIT_TP_EN = 0;
   localparam int BIT_INC = 1;
   localparam int BIT_PRBS = 2;
   localparam int BIT_FRAME = 3;

   // ************************************************************
   // Serial frame: 9 address bits, 1 write bit, 16 data bits
   // ************************************************************
   localparam logic [4:0] SPI_HDR_BITS = 5'h0a;
   localparam logic [4:0] SPI_FRAME_BITS = 5'h1a;

   typedef enum logic [1:0]
   {
      SPI_IDLE = 2'b00,
      SPI_SHIFT = 2'b01,
      SPI_WAIT = 2'b11
   } stp_spi_state_t;

endpackage

// [src/stp_fifo.sv]
// Output FIFO of the test-pattern block, shift-register style.
// Head word sits in a register, so read data come straight from a flop.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module stp_fifo #(
   parameter int WIDTH = 42,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [CW-1:0] cnt;
   } stp_fifo_st_t;

   stp_fifo_st_t s_q;
   stp_fifo_st_t s_d;
   logic push;
   logic pop;

   // ************************************************************
   // Handshakes
   // ************************************************************
   assign in_ready = (s_q.cnt != CW'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = s_q.mem[0];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Shift on pop, then write behind the last live word
   always_comb
   begin
      s_d = s_q;
      if (pop)
      begin
         for (int i = 0; i < DEPTH - 1; i++)
            s_d.mem[i] = s_q.mem[i + 1];
         s_d.mem[DEPTH-1] = '0;
      end
      if (push)
         s_d.mem[s_q.cnt - CW'(pop)] = in_data;
      s_d.cnt = s_q.cnt - CW'(pop) + CW'(push);
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

endmodule

`default_nettype wire

// [src/stp_lane_gen.sv]
// One datapath's synthesized pattern source: constant, ramp or PRBS.
// Assumes the caller steps it once per accepted output word.
`timescale 1ns/1ps
`default_nettype none

module stp_lane_gen #(
   parameter int W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic step,
   input wire logic use_prbs,
   input wire logic use_inc,
   input wire logic [W-1:0] seed,
   output logic [W-1:0] word
);
   typedef struct packed {
      logic [W-1:0] word;
   } stp_lane_st_t;

   stp_lane_st_t s_q;
   stp_lane_st_t s_d;
   logic [W-1:0] seed_nz;

   // LFSR must never start from zero, it would lock there
   assign seed_nz = (seed == '0) ? {{(W-1){1'b0}}, 1'b1} : seed;
   assign word = s_q.word;

   // Next word selection
   always_comb
   begin
      s_d = s_q;
      if (load)
         s_d.word = use_prbs ? seed_nz : seed;
      else if (step)
      begin
         if (use_prbs)
            s_d.word = {s_q.word[W-2:0], s_q.word[W-1] ^ s_q.word[W-4]};
         else if (use_inc)
            s_d.word = s_q.word + {{(W-1){1'b0}}, 1'b1};
         else
            s_d.word = seed;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

endmodule

`default_nettype wire

// [src/stp_test_pattern.sv]
// Test-pattern insertion and calibration-status block of the sensor data
// path, with its serial register port and a 16-word output FIFO.
// Assumes the pixel stream and calibration flags share CLK; the serial
// port pins are asynchronous and are filtered here.
//
// Behaviour
// - Per-channel black calibration fault flags, read-only.
// - Control bit 0 swaps pixels for pattern.
// - Bit 1 selects ramp, else constant value.
// - Bit 2 puts PRBS on all datapaths.
// - Bit 3 frames pattern, else continuous stream.
// - Lane 0/1 low bytes, reset 0 and 1.
// - Lane 2/3 low bytes, reset 2 and 3.
// - Full pattern joins low byte with upper bits.
// - Two upper bits per lane, used when inserting.
`timescale 1ns/1ps
`default_nettype none

module stp_test_pattern #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SPI_CLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_MOSI,
   output logic SPI_MISO,
   output logic SPI_MISO_OE,
   input wire logic PIX_VALID,
   output logic PIX_READY,
   input wire logic [39:0] PIX_DATA,
   input wire logic PIX_SOF,
   input wire logic PIX_EOL,
   input wire logic BLACK_CAL_STROBE,
   input wire logic [7:0] BLACK_CAL_FLAGS,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [39:0] OUT_DATA,
   output logic OUT_SOF,
   output logic OUT_EOL,
   output logic TEST_ACTIVE
);
   localparam int BUS_W = stp_pkg::LANES * stp_pkg::PIX_W;
   localparam int FW = BUS_W + 2;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0] sck_s;
      logic [2:0] cs_s;
      logic [2:0] mosi_s;
      logic sck_lev;
      logic cs_lev;
      logic mosi_lev;
      logic sck_prev;
      stp_pkg::stp_spi_state_t spi_st;
      logic [4:0] bit_cnt;
      logic [25:0] sh_in;
      logic [15:0] sh_out;
      logic miso;
      logic miso_oe;
      logic [15:0] ctrl;
      logic [15:0] low01;
      logic [15:0] low23;
      logic [15:0] high;
      logic [15:0] rsv_set_a;
      logic [15:0] rsv_set_b;
      logic [15:0] rsv_set_c;
      logic [15:0] rsv_set_d;
      logic [7:0] cal_flags;
      logic [3:0] mode_last;
   } stp_core_st_t;

   // Idle bus: clock low, select high
   localparam stp_core_st_t CORE_RST = '{
      sck_s: 3'h0,
      cs_s: 3'h7,
      mosi_s: 3'h0,
      sck_lev: 1'b0,
      cs_lev: 1'b1,
      mosi_lev: 1'b0,
      sck_prev: 1'b0,
      spi_st: stp_pkg::SPI_IDLE,
      bit_cnt: 5'h00,
      sh_in: 26'h0000000,
      sh_out: 16'h0000,
      miso: 1'b0,
      miso_oe: 1'b0,
      ctrl: stp_pkg::RST_CTRL,
      low01: stp_pkg::RST_LOW01,
      low23: stp_pkg::RST_LOW23,
      high: stp_pkg::RST_HIGH,
      rsv_set_a: stp_pkg::RST_ZERO,
      rsv_set_b: stp_pkg::RST_RSV_SET_B,
      rsv_set_c: stp_pkg::RST_ZERO,
      rsv_set_d: stp_pkg::RST_RSV_SET_D,
      cal_flags: 8'h00,
      mode_last: 4'h0
   };

   stp_core_st_t s_q;
   stp_core_st_t s_d;

   logic sck_rise;
   logic sck_fall;
   logic pat_on;
   logic unframed;
   logic use_prbs;
   logic use_inc;
   logic lane_load;
   logic lane_step;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [FW-1:0] fifo_in_data;
   logic [FW-1:0] fifo_out_data;
   logic [BUS_W-1:0] lane_bus;
   logic [stp_pkg::LANES-1:0][stp_pkg::PIX_W-1:0] lane_seed;
   logic [stp_pkg::LANES-1:0][stp_pkg::PIX_W-1:0] lane_word;
   logic [4:0] cnt_next;

   // ************************************************************
   // Register read mux
   // ************************************************************
   // Reserved status words read as zero; reserved settings read back
   function automatic logic [15:0] reg_read(input stp_core_st_t st,
                                            input logic [8:0] a);
      logic [15:0] r;
      r = 16'h0000;
      case (a)
         stp_pkg::ADDR_CAL_FLAGS: r = {8'h00, st.cal_flags};
         stp_pkg::ADDR_RSV_SET_A: r = st.rsv_set_a;
         stp_pkg::ADDR_RSV_SET_B: r = st.rsv_set_b;
         stp_pkg::ADDR_CTRL: r = st.ctrl;
         stp_pkg::ADDR_RSV_SET_C: r = st.rsv_set_c;
         stp_pkg::ADDR_LOW01: r = st.low01;
         stp_pkg::ADDR_LOW23: r = st.low23;
         stp_pkg::ADDR_RSV_SET_D: r = st.rsv_set_d;
         stp_pkg::ADDR_HIGH: r = st.high;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   // ************************************************************
   // Serial edges from filtered levels
   // ************************************************************
   assign sck_rise = s_q.sck_lev & ~s_q.sck_prev;
   assign sck_fall = ~s_q.sck_lev & s_q.sck_prev;
   assign cnt_next = s_q.bit_cnt + 5'h01;

   // ************************************************************
   // Control decode
   // ************************************************************
   // PRBS wins over the synthesized pattern when both are set
   assign use_prbs = s_q.ctrl[stp_pkg::BIT_PRBS];
   assign use_inc = s_q.ctrl[stp_pkg::BIT_INC];
   assign pat_on = s_q.ctrl[stp_pkg::BIT_TP_EN] | use_prbs;
   assign unframed = pat_on & ~s_q.ctrl[stp_pkg::BIT_FRAME];
   assign TEST_ACTIVE = pat_on;

   // Restart generators on any mode change or while idle
   assign lane_load = ~pat_on | (s_q.ctrl[3:0] != s_q.mode_last);

   // ************************************************************
   // Core next-state logic
   // ************************************************************
   always_comb
   begin
      s_d = s_q;
      // Three-stage synchronisers; a change counts when stages 2 and 3 agree
      s_d.sck_s = {s_q.sck_s[1:0], SPI_CLK};
      s_d.cs_s = {s_q.cs_s[1:0], SPI_CS_N};
      s_d.mosi_s = {s_q.mosi_s[1:0], SPI_MOSI};
      if (s_q.sck_s[1] == s_q.sck_s[2])
         s_d.sck_lev = s_q.sck_s[2];
      if (s_q.cs_s[1] == s_q.cs_s[2])
         s_d.cs_lev = s_q.cs_s[2];
      if (s_q.mosi_s[1] == s_q.mosi_s[2])
         s_d.mosi_lev = s_q.mosi_s[2];
      s_d.sck_prev = s_q.sck_lev;
      s_d.mode_last = s_q.ctrl[3:0];

      // Calibration logic reports fault flags as a snapshot
      if (BLACK_CAL_STROBE)
         s_d.cal_flags = BLACK_CAL_FLAGS;

      // Serial register port
      case (s_q.spi_st)
         stp_pkg::SPI_IDLE:
         begin
            if (!s_q.cs_lev)
            begin
               s_d.spi_st = stp_pkg::SPI_SHIFT;
               s_d.bit_cnt = 5'h00;
               s_d.miso = 1'b0;
               s_d.miso_oe = 1'b1;
            end
         end
         stp_pkg::SPI_SHIFT:
         begin
            if (s_q.cs_lev)
            begin
               // Early deselect drops the frame, no write happens
               s_d.spi_st = stp_pkg::SPI_IDLE;
               s_d.miso_oe = 1'b0;
               s_d.miso = 1'b0;
            end
            else if (sck_rise)
            begin
               s_d.sh_in = {s_q.sh_in[24:0], s_q.mosi_lev};
               s_d.bit_cnt = cnt_next;
               if (cnt_next == stp_pkg::SPI_HDR_BITS && !s_q.mosi_lev)
                  s_d.sh_out = reg_read(s_q, s_q.sh_in[8:0]);
               if (cnt_next == stp_pkg::SPI_FRAME_BITS)
               begin
                  s_d.spi_st = stp_pkg::SPI_WAIT;
                  // Reserved settings are writable so that a faithful
                  // read-modify-write keeps their reset contents
                  if (s_q.sh_in[15])
                  begin
                     case (s_q.sh_in[24:16])
                        stp_pkg::ADDR_CTRL:
                           s_d.ctrl = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_LOW01:
                           s_d.low01 = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_LOW23:
                           s_d.low23 = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_HIGH:
                           s_d.high = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_RSV_SET_A:
                           s_d.rsv_set_a = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_RSV_SET_B:
                           s_d.rsv_set_b = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_RSV_SET_C:
                           s_d.rsv_set_c = {s_q.sh_in[14:0], s_q.mosi_lev};
                        stp_pkg::ADDR_RSV_SET_D:
                           s_d.rsv_set_d = {s_q.sh_in[14:0], s_q.mosi_lev};
                        default:
                           s_d.rsv_set_a = s_q.rsv_set_a;
                     endcase
                  end
               end
            end
            else if (sck_fall && s_q.bit_cnt >= stp_pkg::SPI_HDR_BITS)
            begin
               // Read data leaves on falling edges, master samples on rising
               s_d.miso = s_q.sh_out[15];
               s_d.sh_out = {s_q.sh_out[14:0], 1'b0};
            end
         end
         stp_pkg::SPI_WAIT:
         begin
            // Extra clocks after a full frame are ignored until deselect
            if (s_q.cs_lev)
            begin
               s_d.spi_st = stp_pkg::SPI_IDLE;
               s_d.miso_oe = 1'b0;
               s_d.miso = 1'b0;
            end
         end
         default:
         begin
            s_d.spi_st = stp_pkg::SPI_IDLE;
            s_d.miso_oe = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK)
   begin
      if (RST)
         s_q <= CORE_RST;
      else
         s_q <= s_d;
   end

   assign SPI_MISO = s_q.miso;
   assign SPI_MISO_OE = s_q.miso_oe;

   // ************************************************************
   // Pattern seeds: upper pair joined to the low byte
   // ************************************************************
   assign lane_seed[0] = {s_q.high[1:0], s_q.low01[7:0]};
   assign lane_seed[1] = {s_q.high[3:2], s_q.low01[15:8]};
   assign lane_seed[2] = {s_q.high[5:4], s_q.low23[7:0]};
   assign lane_seed[3] = {s_q.high[7:6], s_q.low23[15:8]};

   // ************************************************************
   // Lane generators
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < stp_pkg::LANES; g++)
      begin : gen_lane
         stp_lane_gen #(
            .W(stp_pkg::PIX_W)
         ) u_lane (
            .clk(CLK),
            .rst(RST),
            .load(lane_load),
            .step(lane_step),
            .use_prbs(use_prbs),
            .use_inc(use_inc),
            .seed(lane_seed[g]),
            .word(lane_word[g])
         );
         assign lane_bus[g*stp_pkg::PIX_W +: stp_pkg::PIX_W] = lane_word[g];
      end
   endgenerate

   // ************************************************************
   // Stream selection into the FIFO
   // ************************************************************
   // Unframed: free-running pattern, incoming pixels are drained and dropped
   assign fifo_in_valid = unframed ? ~lane_load : PIX_VALID;
   assign PIX_READY = unframed ? 1'b1 : fifo_in_ready;
   assign lane_step = pat_on & ~lane_load & fifo_in_valid & fifo_in_ready;

   // Framed pattern keeps the incoming frame and line markers
   always_comb
   begin
      if (!pat_on)
         fifo_in_data = {PIX_SOF, PIX_EOL, PIX_DATA};
      else if (unframed)
         fifo_in_data = {2'b00, lane_bus};
      else
         fifo_in_data = {PIX_SOF, PIX_EOL, lane_bus};
   end

   // Output buffer; OUT_READY low stalls the pattern or the pixel source
   stp_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY),
      .out_data(fifo_out_data)
   );

   assign OUT_SOF = fifo_out_data[FW-1];
   assign OUT_EOL = fifo_out_data[FW-2];
   assign OUT_DATA = fifo_out_data[BUS_W-1:0];

endmodule

`default_nettype wire

// [sim/stp_test_pattern_props.sv]
// Concurrent checks on the ports of the test-pattern block.
// Assumes slow serial phases (8 CLK) and a 100 MHz CLK.
`timescale 1ns/1ps
`default_nettype none
module stp_props #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SPI_CLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_MISO,
   input wire logic SPI_MISO_OE,
   input wire logic PIX_VALID,
   input wire logic PIX_READY,
   input wire logic [39:0] PIX_DATA,
   input wire logic PIX_SOF,
   input wire logic PIX_EOL,
   input wire logic OUT_VALID,
   input wire logic OUT_READY,
   input wire logic [39:0] OUT_DATA,
   input wire logic OUT_SOF,
   input wire logic OUT_EOL,
   input wire logic TEST_ACTIVE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Select idle long enough for the filters to settle
   sequence s_cs_idle;
      SPI_CS_N [*8];
   endsequence
   // Pixel word taken in normal mode into an empty FIFO
   sequence s_take_empty;
      PIX_VALID && PIX_READY && !TEST_ACTIVE && !OUT_VALID;
   endsequence
   chk_reset_quiet: assert property ($fell(RST) |-> !OUT_VALID && !TEST_ACTIVE &&
      !SPI_MISO_OE && PIX_READY) else $error("outputs busy after reset");
   chk_pass_through: assert property (s_take_empty |=> OUT_VALID &&
      {OUT_SOF, OUT_EOL, OUT_DATA} == $past({PIX_SOF, PIX_EOL, PIX_DATA}))
      else $error("pixel word not passed through");
   chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
      $stable({OUT_SOF, OUT_EOL, OUT_DATA})) else $error("output word not held");
   chk_ready_empty: assert property (!OUT_VALID |-> PIX_READY)
      else $error("pixels refused with empty fifo");
   chk_oe_idle: assert property (s_cs_idle |-> !SPI_MISO_OE)
      else $error("read data driven while deselected");
   chk_oe_select: assert property ($rose(SPI_MISO_OE) |-> !SPI_CS_N)
      else $error("read driver on without select");
   chk_miso_edge: assert property ($changed(SPI_MISO) |-> !SPI_CLK)
      else $error("read data moved while serial clock high");
   chk_active_steady: assert property (SPI_CS_N [*8] ##1 SPI_CS_N [*4] |=>
      $stable(TEST_ACTIVE)) else $error("pattern state moved without a frame");
endmodule
bind stp_test_pattern stp_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.CLK(CLK), .RST(RST),
   .SPI_CLK(SPI_CLK), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE),
   .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA), .PIX_SOF(PIX_SOF),
   .PIX_EOL(PIX_EOL), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
   .OUT_SOF(OUT_SOF), .OUT_EOL(OUT_EOL), .TEST_ACTIVE(TEST_ACTIVE));
`default_nettype wire

// [sim/stp_rx_model.sv]
// Downstream image receiver: accepts output words, stalls at random.
// Assumes the bench sets hold and the busy percentage.
`timescale 1ns/1ps
`default_nettype none
module stp_rx_model (
   input wire logic clk,
   input wire logic hold,
   input wire logic [7:0] busy_pct,
   output logic ready
);
   // Ready moves just after the edge, never on it
   initial
   begin
      ready = 1'b0;
      forever
      begin
         @(posedge clk);
         #1;
         ready = !hold && (($urandom % 100) >= busy_pct);
      end
   end
endmodule
`default_nettype wire

// [sim/test_stp_test_pattern.sv]
// Self-checking bench for the test-pattern block, fifo depth 4.
// Assumes the serial port frame of the package and a 100 MHz CLK.
`timescale 1ns/1ps
`default_nettype none
module test_stp_test_pattern;
   localparam int DEPTH = 4;
   logic CLK = 0, RST = 1, SPI_CLK = 0, SPI_CS_N = 1, SPI_MOSI = 0, hold = 0;
   logic PIX_VALID = 0, PIX_SOF = 0, PIX_EOL = 0, BLACK_CAL_STROBE = 0;
   logic [39:0] PIX_DATA = '0;
   logic [7:0] BLACK_CAL_FLAGS = '0, busy = '0, f;
   logic [15:0] ctl, lo01, lo23, hi, r;
   logic [9:0] gen [4];
   logic [41:0] exp_q [$];
   int n_mismatch = 0, n_checks = 0;
   wire logic SPI_MISO, SPI_MISO_OE, PIX_READY, OUT_VALID, OUT_READY, OUT_SOF, OUT_EOL;
   wire logic TEST_ACTIVE;
   wire logic [39:0] OUT_DATA;
   stp_test_pattern #(.FIFO_DEPTH(DEPTH)) uut (.CLK(CLK), .RST(RST), .SPI_CLK(SPI_CLK),
      .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO), .SPI_MISO_OE(SPI_MISO_OE),
      .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA), .PIX_SOF(PIX_SOF),
      .PIX_EOL(PIX_EOL), .BLACK_CAL_STROBE(BLACK_CAL_STROBE), .BLACK_CAL_FLAGS(BLACK_CAL_FLAGS),
      .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_SOF(OUT_SOF),
      .OUT_EOL(OUT_EOL), .TEST_ACTIVE(TEST_ACTIVE));
   stp_rx_model rx (.clk(CLK), .hold(hold), .busy_pct(busy), .ready(OUT_READY));
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic cmp_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_word(input string nm, input logic [41:0] e, input logic [41:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Serial frame, MSB first; phases of 8 CLK keep clear of the filters
   task automatic spi(input logic [8:0] a, input logic w, input logic [15:0] d);
      logic [25:0] fr;
      fr = {a, w, d};
      SPI_CS_N = 0;
      for (int i = 25; i >= 0; i--)
      begin
         SPI_MOSI = fr[i];
         tick(8);
         if (i < 16) r[i] = SPI_MISO;
         SPI_CLK = 1;
         tick(8);
         SPI_CLK = 0;
      end
      tick(8);
      SPI_CS_N = 1;
      tick(8);
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
      spi(a, 1'b0, 16'h0000);
      cmp_reg("register", e, r);
   endtask
   // Pattern generator model: ramp wraps at 10 bits, PRBS wins
   task automatic step_gen();
      for (int l = 0; l < 4; l++)
         gen[l] = ctl[2] ? {gen[l][8:0], gen[l][9] ^ gen[l][6]} : gen[l] + {9'h000, ctl[1]};
   endtask
   task automatic load_gen();
      for (int l = 0; l < 4; l++)
      begin
         gen[l] = {hi[2*l +: 2], l < 2 ? lo01[8*l +: 8] : lo23[8*(l-2) +: 8]};
         if (ctl[2] && gen[l] == 10'h000) gen[l] = 10'h001;
      end
   endtask
   // Offers n pixel words and notes what must come out for each
   task automatic send_pix(input int n);
      for (int k = 0; k < n; k++)
      begin
         PIX_VALID = 1;
         PIX_DATA = {8'($urandom), $urandom};
         PIX_SOF = 1'($urandom);
         PIX_EOL = 1'($urandom);
         for (int g = 0; g < 500 && PIX_READY !== 1'b1; g++) tick(1);
         exp_q.push_back({PIX_SOF, PIX_EOL, (ctl[0] | ctl[2]) ? {gen[3], gen[2], gen[1], gen[0]} : PIX_DATA});
         if (ctl[0] | ctl[2]) step_gen();
         tick(1);
      end
      PIX_VALID = 0;
   endtask
   task automatic drain();
      for (int g = 0; g < 3000 && exp_q.size() != 0; g++) tick(1);
      tick(4);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ************************************************************
   // Processes
   // ************************************************************
   // Clock
   initial
   begin
      forever #5 CLK = ~CLK;
   end
   // Output monitor: oldest note against each accepted word
   always @(posedge CLK)
   begin
      if (RST === 1'b0 && OUT_VALID === 1'b1 && OUT_READY === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            n_mismatch++;
            $display("mismatch out_word expected none seen %h", OUT_DATA);
         end
         else
            cmp_word("out_word", exp_q.pop_front(), {OUT_SOF, OUT_EOL, OUT_DATA});
      end
   end
   // Watchdog, well past the expected run length
   initial
   begin
      repeat (90000) @(posedge CLK);
      n_mismatch++;
      wrap_up();
   end
   // Main sequence
   initial
   begin
      logic [15:0] modes [6];
      modes = '{16'h0001, 16'h0003, 16'h0004, 16'h0009, 16'h000b, 16'h000e};
      void'($urandom(60));
      ctl = 16'h0000;
      tick(3);
      RST = 0;
      tick(6);
      rd_chk(stp_pkg::ADDR_CTRL, stp_pkg::RST_CTRL);
      rd_chk(stp_pkg::ADDR_LOW01, stp_pkg::RST_LOW01);
      rd_chk(stp_pkg::ADDR_LOW23, stp_pkg::RST_LOW23);
      rd_chk(stp_pkg::ADDR_HIGH, stp_pkg::RST_HIGH);
      rd_chk(stp_pkg::ADDR_RSV_SET_B, stp_pkg::RST_RSV_SET_B);
      rd_chk(stp_pkg::ADDR_RSV_SET_D, stp_pkg::RST_RSV_SET_D);
      rd_chk(stp_pkg::ADDR_CAL_FLAGS, stp_pkg::RST_ZERO);
      // Read-only and unmapped places ignore writes
      spi(stp_pkg::ADDR_RSV_STAT_A, 1'b1, 16'h5a5a);
      rd_chk(stp_pkg::ADDR_RSV_STAT_A, stp_pkg::RST_ZERO);
      spi(9'h1ff, 1'b1, 16'ha5a5);
      rd_chk(9'h1ff, 16'h0000);
      // Fault flags: snapshot per strobe, software write ignored
      repeat (2)
      begin
         f = 8'($urandom);
         BLACK_CAL_FLAGS = f;
         BLACK_CAL_STROBE = 1;
         tick(1);
         BLACK_CAL_STROBE = 0;
         BLACK_CAL_FLAGS = ~f;
         spi(stp_pkg::ADDR_CAL_FLAGS, 1'b1, 16'hffff);
         rd_chk(stp_pkg::ADDR_CAL_FLAGS, {8'h00, f});
      end
      // Normal flow with a stalled receiver so the fifo refuses
      busy = 8'd40;
      hold = 1;
      fork
         begin
            tick(80);
            hold = 0;
         end
      join_none
      send_pix(12);
      drain();
      // Every pattern mode; lane seeds near the top in mode 1 (unframed ramp) to see the ramp wrap
      for (int m = 0; m < 6; m++)
      begin
         ctl = modes[m];
         lo01 = m == 1 ? 16'hfeff : 16'($urandom);
         lo23 = m == 1 ? 16'hfdfc : 16'($urandom);
         hi = {8'h00, m == 1 ? 8'hff : 8'($urandom)};
         spi(stp_pkg::ADDR_LOW01, 1'b1, lo01);
         spi(stp_pkg::ADDR_LOW23, 1'b1, lo23);
         spi(stp_pkg::ADDR_HIGH, 1'b1, hi);
         rd_chk(stp_pkg::ADDR_HIGH, hi);
         load_gen();
         hold = !ctl[3];
         spi(stp_pkg::ADDR_CTRL, 1'b1, ctl);
         cmp_reg("test_active", {15'h0000, ctl[0] | ctl[2]}, {15'h0000, TEST_ACTIVE});
         if (ctl[3])
            send_pix(6);
         spi(stp_pkg::ADDR_CTRL, 1'b1, 16'h0000);
         if (!ctl[3])
         begin
            // Unframed: the stalled fifo holds exactly DEPTH pattern words
            repeat (DEPTH)
            begin
               exp_q.push_back({2'b00, gen[3], gen[2], gen[1], gen[0]});
               step_gen();
            end
         end
         hold = 0;
         drain();
      end
      // Second reset restores the lane bytes
      RST = 1;
      tick(3);
      RST = 0;
      tick(6);
      rd_chk(stp_pkg::ADDR_LOW01, stp_pkg::RST_LOW01);
      wrap_up();
   end
endmodule
`default_nettype wire
